// file: rtl/fdstat_regs.vh
`ifndef FDSTAT_REGS_VH
`define FDSTAT_REGS_VH
// Register select on the two address lines
`define FDSTAT_SEL_STATUS 2'h0
`define FDSTAT_SEL_DATA 2'h3
// Status bit positions
`define FDSTAT_B_NOTRDY 7
`define FDSTAT_B_PROT 6
`define FDSTAT_B_HEAD 5
`define FDSTAT_B_RNF 4
`define FDSTAT_B_CRC 3
`define FDSTAT_B_LOST 2
`define FDSTAT_B_REQ 1
`define FDSTAT_B_BUSY 0
// Command types
`define FDSTAT_CT_SEEK 2'h0
`define FDSTAT_CT_READ 2'h1
`define FDSTAT_CT_WRITE 2'h2
`define FDSTAT_CT_ABORT 2'h3
// Track write byte that calls for the two checksum bytes
`define FDSTAT_CRC_CODE 8'hF7
// One byte time, ns, and in 40 ns clocks (rounded down)
`define FDSTAT_BYTE_NS 32000
`define FDSTAT_BYTE_CYC ((`FDSTAT_BYTE_NS) / 40)
`endif

// file: rtl/fdstat_buf.v
`timescale 1ns/1ps
// ==========================================
// Two-entry valid/ready buffer
module fdstat_buf (
  // Clock and reset
  input wire clock_i,
  input wire rst_i,
  input wire flush_i,
  // Fill side
  input wire [7:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  // Drain side
  output wire [7:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [7:0] mem [0:1];
  reg wr_ptr;
  reg rd_ptr;
  reg [1:0] count;
  wire push;
  wire pop;
  assign in_ready_o = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else if (flush_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // fdstat_buf

// file: rtl/fdstat_lost.v
`timescale 1ns/1ps
`include "fdstat_regs.vh"
// ==========================================
// Byte-time watchdog on a pending request
module fdstat_lost (
  // Clock and reset
  input wire clock_i,
  input wire rst_i,
  // Control
  input wire pending_i,
  // Result
  output reg expired_o
);
  localparam integer LIMIT_FULL = `FDSTAT_BYTE_CYC;
  localparam [15:0] LIMIT = LIMIT_FULL[15:0];
  reg [15:0] count;
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count <= 16'h0000;
      expired_o <= 1'b0;
    end else if (!pending_i) begin
      count <= 16'h0000;
      expired_o <= 1'b0;
    end else begin
      expired_o <= (count == LIMIT - 16'h0001);
      if (count != LIMIT) begin
        count <= count + 16'h0001;
      end
    end
  end
endmodule // fdstat_lost

// file: rtl/fdstat_core.v
`timescale 1ns/1ps
`include "fdstat_regs.vh"
// Summary of operation
// - Bit 7 is inverted ready, forced high during master reset
// - Seek status: bit 6 is inverted write-protect input
// - Seek status: bit 5 is head-load out AND head-load-timing in
// - Seek status: bit 4 flags unverified track, cleared on update
// - Seek status: bit 3 flags identification checksum failure
// - Seek status: bit 2 is inverted track-zero input
// - Seek status: bit 1 is inverted index-pulse input
// - Bit 0 is busy while any command executes
// - Read/write commands refused while drive is not ready
// - Bit 6: zero on reads, write protect on writes, cleared on update
// - Bit 5: deleted mark type on reads, write fault on writes
// - Bit 4 flags record not found, cleared on update
// - Bit 3: id checksum error if bit 4 set, else data checksum
// - Bit 2 flags byte request not serviced in one byte time
// - Bit 1 mirrors the byte request output
// - No index mark needed; gaps 1, 3, 4 may be 2 bytes
// - Host byte F7 in a track write emits two checksum bytes; here it is passed on as one byte with wr_crc_o set
// - Data register access clears byte request and its status bit
// - Starting a non-abort command sets busy and refreshes status
module fdstat_core (
  // Clock and reset
  input wire clock_i,
  input wire rst_i,
  input wire master_reset_in_i,
  // Host register port
  input wire [1:0] reg_sel_i,
  input wire rd_stb_i,
  input wire wr_stb_i,
  input wire [7:0] wr_data_i,
  output reg [7:0] rd_data_o,
  // Command sequencer
  input wire cmd_start_i,
  input wire [1:0] cmd_type_i,
  input wire cmd_done_i,
  input wire seek_err_i,
  input wire id_crc_err_i,
  input wire data_crc_err_i,
  input wire rec_missing_i,
  input wire deleted_mark_i,
  input wire write_fault_i,
  input wire need_byte_i,
  input wire [7:0] disk_byte_i,
  input wire disk_byte_valid_i,
  output reg cmd_refused_o,
  // Drive
  input wire ready_in_i,
  input wire write_protect_in_i,
  input wire head_load_timing_in_i,
  input wire track_zero_in_i,
  input wire index_pulse_in_i,
  output reg head_load_out_o,
  // Byte stream to write path
  output reg [7:0] wr_byte_o,
  output reg wr_byte_valid_o,
  output reg wr_crc_o,
  input wire wr_byte_ready_i,
  // Status
  output reg byte_request_o,
  output reg busy_o
);
  // ==========================================
  // State
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [1:0] last_type;
  reg prot;
  reg head_bit;
  reg record_missing_flag;
  reg crc;
  reg lost;
  reg [7:0] data_holding_register;
  reg next_request;
  wire data_rd;
  wire data_wr;
  wire is_write;
  wire is_read;
  wire rw_type;
  wire lost_expired;
  wire buf_in_ready;
  wire [7:0] buf_data;
  wire buf_valid;
  wire take;
  wire accept;
  wire refuse;
  wire [7:0] status;
  assign data_rd = rd_stb_i & (reg_sel_i == `FDSTAT_SEL_DATA);
  assign data_wr = wr_stb_i & (reg_sel_i == `FDSTAT_SEL_DATA);
  assign is_write = (last_type == `FDSTAT_CT_WRITE);
  assign is_read = (last_type == `FDSTAT_CT_READ);
  assign rw_type = is_write | is_read;
  // Not ready blocks only read/write types; seeks still run
  assign refuse = cmd_start_i & ~ready_in_i & ((cmd_type_i == `FDSTAT_CT_READ) |
                  (cmd_type_i == `FDSTAT_CT_WRITE));
  assign accept = cmd_start_i & ~refuse & (cmd_type_i != `FDSTAT_CT_ABORT);
  // ==========================================
  // Write stream buffer: holds host bytes while the write path stalls
  fdstat_buf u_buf (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .flush_i(accept),
    .in_data_i(data_holding_register),
    .in_valid_i(take),
    .in_ready_o(buf_in_ready),
    .out_data_o(buf_data),
    .out_valid_o(buf_valid),
    .out_ready_i(~wr_byte_valid_o | wr_byte_ready_i)
  );
  // Host byte moves to the buffer once written and the request is down
  assign take = is_write & busy_o & ~byte_request_o & need_byte_i & buf_in_ready;
  // ==========================================
  // Lost data watchdog
  fdstat_lost u_lost (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pending_i(byte_request_o & busy_o),
    .expired_o(lost_expired)
  );
  // ==========================================
  // Command sequencing
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cmd_done_i | (cmd_start_i & (cmd_type_i == `FDSTAT_CT_ABORT))) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        // A start in the closing cycle must not leave busy set while idle
        next_state = accept ? ST_RUN : ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end
  // Byte request: raised by the read path or by write demand
  always @* begin
    next_request = byte_request_o;
    if (data_rd | data_wr) begin
      next_request = 1'b0;
    end
    if (busy_o & is_read & disk_byte_valid_i) begin
      next_request = 1'b1;
    end
    if (busy_o & is_write & need_byte_i & ~byte_request_o & buf_in_ready & ~data_wr) begin
      next_request = 1'b1;
    end
    if (state == ST_DONE) begin
      next_request = 1'b0;
    end
    // A start drops whatever the previous command left pending
    if (accept) begin
      next_request = (cmd_type_i == `FDSTAT_CT_WRITE);
    end
  end
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      last_type <= `FDSTAT_CT_SEEK;
      busy_o <= 1'b0;
      byte_request_o <= 1'b0;
      cmd_refused_o <= 1'b0;
      head_load_out_o <= 1'b0;
      prot <= 1'b0;
      head_bit <= 1'b0;
      record_missing_flag <= 1'b0;
      crc <= 1'b0;
      lost <= 1'b0;
      data_holding_register <= 8'h00;
    end else begin
      state <= next_state;
      cmd_refused_o <= refuse;
      byte_request_o <= next_request;
      if (accept) begin
        last_type <= cmd_type_i;
        busy_o <= 1'b1;
        head_load_out_o <= 1'b1;
        prot <= 1'b0;
        head_bit <= 1'b0;
        record_missing_flag <= 1'b0;
        crc <= 1'b0;
        lost <= 1'b0;
      end else begin
        if (state == ST_DONE) begin
          busy_o <= 1'b0;
        end
        if (busy_o) begin
          if (is_write & write_protect_in_i) begin
            prot <= 1'b1;
          end
          if (is_write & write_fault_i) begin
            head_bit <= 1'b1;
          end
          if (is_read & disk_byte_valid_i) begin
            head_bit <= deleted_mark_i;
          end
          if (seek_err_i | rec_missing_i) begin
            record_missing_flag <= 1'b1;
          end
          if (id_crc_err_i | data_crc_err_i) begin
            crc <= 1'b1;
          end
          if (lost_expired) begin
            lost <= 1'b1;
          end
        end
      end
      if (is_read & busy_o & disk_byte_valid_i) begin
        data_holding_register <= disk_byte_i;
      end else if (data_wr) begin
        data_holding_register <= wr_data_i;
      end
    end
  end
  // ==========================================
  // Checksum code is passed on as a data byte, with wr_crc_o marking it
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_byte_o <= 8'h00;
      wr_byte_valid_o <= 1'b0;
      wr_crc_o <= 1'b0;
    end else if (~wr_byte_valid_o | wr_byte_ready_i) begin
      wr_byte_valid_o <= buf_valid;
      // No index mark or gap length is checked; bytes pass as given
      wr_byte_o <= buf_data;
      wr_crc_o <= buf_valid & (buf_data == `FDSTAT_CRC_CODE);
    end
  end
  // ==========================================
  // Status assembly
  assign status[`FDSTAT_B_NOTRDY] = ~ready_in_i | master_reset_in_i;
  assign status[`FDSTAT_B_PROT] = rw_type ? (is_write & prot) : ~write_protect_in_i;
  assign status[`FDSTAT_B_HEAD] = rw_type ? head_bit :
                                  (head_load_out_o & head_load_timing_in_i);
  assign status[`FDSTAT_B_RNF] = record_missing_flag;
  assign status[`FDSTAT_B_CRC] = crc;
  assign status[`FDSTAT_B_LOST] = rw_type ? lost : ~track_zero_in_i;
  assign status[`FDSTAT_B_REQ] = rw_type ? byte_request_o : ~index_pulse_in_i;
  assign status[`FDSTAT_B_BUSY] = busy_o;
  // Registered read port; other selects read as zero
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= 8'h80;
    end else if (rd_stb_i & (reg_sel_i == `FDSTAT_SEL_STATUS)) begin
      rd_data_o <= status;
    end else if (data_rd) begin
      rd_data_o <= data_holding_register;
    end else begin
      rd_data_o <= 8'h00;
    end
  end
endmodule // fdstat_core

// file: bench/fdstat_chk.sv
`timescale 1ns/1ps
`include "fdstat_regs.vh"
// ====
// Status port checker
module fdstat_chk (
  // Clock and reset
  input wire clock_i,
  input wire rst_i,
  // Host side
  input wire master_reset_in_i,
  input wire [1:0] reg_sel_i,
  input wire rd_stb_i,
  input wire wr_stb_i,
  input wire [7:0] rd_data_o,
  input wire cmd_start_i,
  input wire [1:0] cmd_type_i,
  input wire cmd_done_i,
  input wire cmd_refused_o,
  input wire need_byte_i,
  input wire disk_byte_valid_i,
  // Drive and write path
  input wire ready_in_i,
  input wire head_load_out_o,
  input wire [7:0] wr_byte_o,
  input wire wr_byte_valid_o,
  input wire wr_crc_o,
  input wire wr_byte_ready_i,
  // Status
  input wire byte_request_o,
  input wire busy_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire rw = cmd_type_i == `FDSTAT_CT_READ || cmd_type_i == `FDSTAT_CT_WRITE;
  sequence s_rd;
    rd_stb_i && reg_sel_i == `FDSTAT_SEL_STATUS;
  endsequence
  sequence s_acc;
    cmd_start_i && !busy_o && cmd_type_i != `FDSTAT_CT_ABORT && (ready_in_i || !rw);
  endsequence
  sequence s_ref;
    cmd_start_i && !busy_o && rw && !ready_in_i;
  endsequence
  // Excludes a new byte landing in the same cycle as the access
  sequence s_dr;
    byte_request_o && (rd_stb_i || wr_stb_i) && reg_sel_i == `FDSTAT_SEL_DATA
      && !disk_byte_valid_i && !need_byte_i && !cmd_start_i;
  endsequence
  AST_NOT_READY: assert property (s_rd |=> rd_data_o[7] == $past(!ready_in_i || master_reset_in_i))
    else $error("not ready bit wrong");
  AST_BUSY_BIT: assert property (s_rd |=> rd_data_o[0] == $past(busy_o))
    else $error("busy bit wrong");
  AST_REFUSED: assert property (s_ref |=> cmd_refused_o ##1 !cmd_refused_o)
    else $error("refusal pulse wrong");
  AST_NO_START: assert property (s_ref ##1 !cmd_start_i [*2] |-> !busy_o [*2])
    else $error("refused command started");
  AST_BUSY_SET: assert property (s_acc |-> ##[1:2] busy_o)
    else $error("busy not set");
  AST_BUSY_DROP: assert property (cmd_done_i && busy_o && !cmd_start_i ##1 !cmd_start_i
    |-> ##[0:2] !busy_o)
    else $error("busy not dropped");
  AST_REQ_CLEAR: assert property (s_dr |=> !byte_request_o)
    else $error("request not cleared");
  AST_HEAD_LOAD: assert property (s_acc |-> ##[1:2] head_load_out_o)
    else $error("head not loaded");
  AST_REQ_START: assert property (s_acc ##0 cmd_type_i != `FDSTAT_CT_WRITE |=> !byte_request_o)
    else $error("request raised by non-write start");
  AST_STALL_HOLD: assert property (wr_byte_valid_o && !wr_byte_ready_i |=>
    wr_byte_valid_o && $stable(wr_byte_o) && $stable(wr_crc_o))
    else $error("stalled byte lost");
endmodule // fdstat_chk

bind fdstat_core fdstat_chk i_chk (.clock_i, .rst_i, .master_reset_in_i, .reg_sel_i,
  .rd_stb_i, .wr_stb_i, .rd_data_o, .cmd_start_i, .cmd_type_i, .cmd_done_i,
  .cmd_refused_o, .need_byte_i, .disk_byte_valid_i, .ready_in_i, .head_load_out_o,
  .wr_byte_o, .wr_byte_valid_o, .wr_crc_o, .wr_byte_ready_i, .byte_request_o, .busy_o);

// file: bench/fdstat_drive_model.sv
`timescale 1ns/1ps
// ====
// Drive levels and write byte sink
module fdstat_drive_model (
  // Clock and reset
  input wire clock_i,
  input wire rst_i,
  // Bench control
  input wire [4:0] lv_i,
  input wire stall_i,
  // Drive pins
  output wire ready_o,
  output wire write_protect_o,
  output wire head_load_timing_o,
  output wire track_zero_o,
  output wire index_pulse_o,
  // Write byte sink
  input wire wr_valid_i,
  input wire wr_crc_i,
  output wire wr_ready_o,
  output reg got_crc_o,
  output reg [7:0] n_got_o
);
  assign {ready_o, write_protect_o, head_load_timing_o, track_zero_o, index_pulse_o} = lv_i;
  assign wr_ready_o = !stall_i;
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      got_crc_o <= 1'b0;
      n_got_o <= 8'h00;
    end else if (wr_valid_i && !stall_i) begin
      got_crc_o <= wr_crc_i;
      n_got_o <= n_got_o + 8'h01;
    end
  end
endmodule // fdstat_drive_model

// file: bench/tb_fdstat_core.sv
`timescale 1ns/1ps
`include "fdstat_regs.vh"
module tb_fdstat_core;
  logic clock_i, rst_i, master_reset_in_i, rd_stb_i, wr_stb_i, cmd_start_i, cmd_done_i;
  logic seek_err_i, id_crc_err_i, data_crc_err_i, rec_missing_i, deleted_mark_i;
  logic write_fault_i, need_byte_i, disk_byte_valid_i, stall;
  logic [1:0] reg_sel_i, cmd_type_i;
  logic [7:0] wr_data_i, disk_byte_i, d;
  logic [4:0] lv;
  wire [7:0] rd_data_o, wr_byte_o, n_got;
  wire cmd_refused_o, head_load_out_o, wr_byte_valid_o, wr_crc_o, wr_byte_ready_i;
  wire byte_request_o, busy_o, got_crc, ready_in_i, write_protect_in_i;
  wire head_load_timing_in_i, track_zero_in_i, index_pulse_in_i;
  int n_mismatch, tests_run;
  fdstat_core i_dut (.clock_i, .rst_i, .master_reset_in_i, .reg_sel_i, .rd_stb_i, .wr_stb_i,
    .wr_data_i, .rd_data_o, .cmd_start_i, .cmd_type_i, .cmd_done_i, .seek_err_i,
    .id_crc_err_i, .data_crc_err_i, .rec_missing_i, .deleted_mark_i, .write_fault_i,
    .need_byte_i, .disk_byte_i, .disk_byte_valid_i, .cmd_refused_o, .ready_in_i,
    .write_protect_in_i, .head_load_timing_in_i, .track_zero_in_i, .index_pulse_in_i,
    .head_load_out_o, .wr_byte_o, .wr_byte_valid_o, .wr_crc_o, .wr_byte_ready_i,
    .byte_request_o, .busy_o);
  fdstat_drive_model i_drv (.clock_i(clock_i), .rst_i(rst_i), .lv_i(lv), .stall_i(stall),
    .ready_o(ready_in_i), .write_protect_o(write_protect_in_i),
    .head_load_timing_o(head_load_timing_in_i), .track_zero_o(track_zero_in_i),
    .index_pulse_o(index_pulse_in_i), .wr_valid_i(wr_byte_valid_o), .wr_crc_i(wr_crc_o),
    .wr_ready_o(wr_byte_ready_i), .got_crc_o(got_crc), .n_got_o(n_got));
  // ====
  // Shared tasks
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  function automatic logic sig(input int k);
    return k == 0 ? busy_o : k == 1 ? byte_request_o : wr_byte_valid_o;
  endfunction
  // Bounded wait; a timeout ends the run
  task automatic wait_for(input int k, input logic v);
    int i;
    for (i = 0; i < 50 && sig(k) !== v; i++) tick(1);
    chk("wait", {7'h0, sig(k)}, {7'h0, v});
    if (sig(k) !== v) close_out();
  endtask
  task automatic acc(input logic [1:0] s, input logic w, input logic [7:0] v);
    reg_sel_i = s;
    wr_data_i = v;
    rd_stb_i = !w;
    wr_stb_i = w;
    tick(1);
    rd_stb_i = 0;
    wr_stb_i = 0;
    d = rd_data_o;
    // Idle edge so a following access never re-raises a strobe in the same step
    tick(1);
  endtask
  // Host supplies n copies of a byte through the request handshake
  task automatic put(input logic [7:0] v, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      wait_for(1, 1);
      acc(`FDSTAT_SEL_DATA, 1, v);
      need_byte_i = 1;
      tick(1);
      need_byte_i = 0;
    end
  endtask
  task automatic go(input logic [1:0] t);
    cmd_type_i = t;
    cmd_start_i = 1;
    tick(1);
    cmd_start_i = 0;
  endtask
  task automatic finish_cmd();
    cmd_done_i = 1;
    tick(1);
    cmd_done_i = 0;
    wait_for(0, 0);
  endtask
  // ====
  // Scenarios
  task automatic t_seek();
    lv = 5'b11101;
    go(`FDSTAT_CT_SEEK);
    wait_for(0, 1);
    seek_err_i = 1;
    id_crc_err_i = 1;
    tick(1);
    seek_err_i = 0;
    id_crc_err_i = 0;
    chk("head", {7'h0, head_load_out_o}, 8'h01);
    acc(`FDSTAT_SEL_STATUS, 0, 8'h00);
    chk("seek_a", d, 8'h3D);
    lv = 5'b00010;
    acc(`FDSTAT_SEL_STATUS, 0, 8'h00);
    chk("seek_b", d, 8'hDB);
    finish_cmd();
    acc(`FDSTAT_SEL_STATUS, 0, 8'h00);
    chk("seek_idle", d, 8'hDA);
    lv = 5'b10111;
    go(`FDSTAT_CT_SEEK);
    wait_for(0, 1);
    acc(`FDSTAT_SEL_STATUS, 0, 8'h00);
    chk("seek_new", d, 8'h61);
    finish_cmd();
  endtask
  task automatic t_refuse();
    int t;
    lv = 5'b00000;
    for (t = 1; t < 3; t++) begin
      go(t[1:0]);
      chk("refused", {7'h0, cmd_refused_o}, 8'h01);
      tick(1);
      chk("no_busy", {6'h0, cmd_refused_o, busy_o}, 8'h00);
    end
    lv = 5'b10000;
    go(`FDSTAT_CT_ABORT);
    tick(2);
    chk("abort", {7'h0, busy_o}, 8'h00);
    master_reset_in_i = 1;
    acc(`FDSTAT_SEL_STATUS, 0, 8'h00);
    master_reset_in_i = 0;
    chk("mr", {7'h0, d[7]}, 8'h01);
    acc(`FDSTAT_SEL_STATUS, 0, 8'h00);
    chk("mr_off", {7'h0, d[7]}, 8'h00);
  endtask
  task automatic t_read();
    go(`FDSTAT_CT_READ);
    wait_for(0, 1);
    {deleted_mark_i, disk_byte_valid_i, rec_missing_i, id_crc_err_i} = 4'hF;
    disk_byte_i = 8'hA5;
    tick(1);
    {disk_byte_valid_i, rec_missing_i, id_crc_err_i} = 3'h0;
    wait_for(1, 1);
    tick(850);
    acc(`FDSTAT_SEL_STATUS, 0, 8'h00);
    chk("rd_st", d, 8'h3F);
    acc(`FDSTAT_SEL_DATA, 0, 8'h00);
    chk("rd_dr", d, 8'hA5);
    chk("rd_req", {7'h0, byte_request_o}, 8'h00);
    acc(`FDSTAT_SEL_STATUS, 0, 8'h00);
    chk("rd_st2", d, 8'h3D);
    deleted_mark_i = 0;
    finish_cmd();
  endtask
  task automatic t_write();
    lv = 5'b11000;
    stall = 1;
    go(`FDSTAT_CT_WRITE);
    wait_for(0, 1);
    wait_for(1, 1);
    // Protect flag is latched on the first busy edge
    tick(1);
    acc(`FDSTAT_SEL_STATUS, 0, 8'h00);
    chk("wr_st", d, 8'h43);
    acc(`FDSTAT_SEL_DATA, 1, `FDSTAT_CRC_CODE);
    chk("wr_req", {7'h0, byte_request_o}, 8'h00);
    need_byte_i = 1;
    wait_for(2, 1);
    need_byte_i = 0;
    tick(3);
    chk("stalled", n_got, 8'h00);
    chk("crc_flag", {7'h0, wr_crc_o}, 8'h01);
    chk("wr_byte", wr_byte_o, `FDSTAT_CRC_CODE);
    stall = 0;
    tick(2);
    chk("sink", {n_got[6:0], got_crc}, 8'h03);
    write_fault_i = 1;
    data_crc_err_i = 1;
    tick(1);
    write_fault_i = 0;
    data_crc_err_i = 0;
    acc(`FDSTAT_SEL_STATUS, 0, 8'h00);
    chk("wr_flt", d & 8'hFD, 8'h69);
    go(`FDSTAT_CT_ABORT);
    wait_for(0, 0);
    acc(`FDSTAT_SEL_STATUS, 0, 8'h00);
    chk("abort_st", d, 8'h68);
  endtask
  task automatic t_format();
    int s;
    go(`FDSTAT_CT_WRITE);
    put(8'hFF, 11);
    put(8'h00, 6);
    put(8'hE5, 128);
    put(`FDSTAT_CRC_CODE, 1);
    put(8'hFF, 10);
    put(8'h00, 4);
    // Double density gap pattern, F5 standing for each A1 mark
    for (s = 0; s < 26; s++) begin
      put(8'h4E, 16);
      put(8'h00, 8);
      put(8'hF5, 3);
    end
    put(8'h4E, 16);
    tick(2);
    finish_cmd();
    // One earlier byte plus 878 streamed, modulo 256
    chk("format", n_got, 8'h6F);
  endtask
  initial begin
    clock_i = 0;
    forever #20 clock_i = ~clock_i;
  end
  initial begin
    {master_reset_in_i, rd_stb_i, wr_stb_i, cmd_start_i, cmd_done_i, seek_err_i} = '0;
    {id_crc_err_i, data_crc_err_i, rec_missing_i, deleted_mark_i, write_fault_i} = '0;
    {need_byte_i, disk_byte_valid_i, stall, reg_sel_i, cmd_type_i} = '0;
    {wr_data_i, disk_byte_i, lv} = '0;
    n_mismatch = 0;
    tests_run = 0;
    rst_i = 1;
    repeat (3) @(posedge clock_i);
    #1 rst_i = 0;
    t_seek();
    t_refuse();
    t_read();
    t_write();
    t_format();
    close_out();
  end
endmodule // tb_fdstat_core
